// ==== borrow_exec.sv ====
`timescale 1ns/1ns
`include "borrow_exec_cfg.svh"

module borrow_exec (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Instruction issue
  input wire logic instr_valid_i,
  input wire borrow_exec_pkg::word_t instr_i,
  input wire logic ext_fetch_i,
  input wire logic [3:0] wait_p_i,
  input wire logic rpt_valid_i,
  input wire logic [7:0] rpt_n_i,
  output logic instr_ready_o,
  output logic done_o,
  output logic rpt_refused_o,
  // Core state
  output borrow_exec_pkg::word_t pc_o,
  output logic xf_o,
  output logic global_irq_mask_bit_o,
  output logic hm_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire borrow_exec_pkg::dword_t pwdata_i,
  output borrow_exec_pkg::dword_t prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import borrow_exec_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  function automatic op_e decode_op(input word_t w);
    if (w == `OPC_SUBTRACT_BUFFER_WITH_BORROW) begin
      decode_op = OP_SUBTRACT_BUFFER_WITH_BORROW;
    end else if (w[15:8] == `OPC_POINTER_SUBTRACT_IMMEDIATE_HI) begin
      decode_op = OP_POINTER_SUBTRACT_IMMEDIATE;
    end else if (w[15:4] == `OPC_SET_CONTROL_BIT_OP_HI) begin
      decode_op = OP_SET_CONTROL_BIT_OP;
    end else begin
      decode_op = OP_NONE;
    end
  endfunction : decode_op

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `OFS_ACC) || (a == `OFS_SHADOW_SUM_REGISTER) || (a == `OFS_ST0) ||
                (a == `OFS_ST1) || (a == `OFS_AR_IDX) || (a == `OFS_AR_DATA) ||
                (a == `OFS_EXEC);
  endfunction : is_mapped

  // ****************************************
  // State
  // ****************************************
  dword_t acc_reg, acc_next;
  dword_t shadow_sum_register_reg, shadow_sum_register_next;
  word_t st0_reg, st0_next;
  word_t st1_reg, st1_next;
  word_t pc_reg, pc_next;
  word_t ar_reg [8];
  word_t ar_next [8];
  logic [2:0] ar_idx_reg, ar_idx_next;
  op_e op_reg, op_next;
  word_t instr_reg, instr_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic refused_reg, refused_next;
  dword_t prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic slverr_reg, slverr_next;
  logic accept;
  op_e new_op;
  logic [7:0] reps;
  logic fire;
  logic last;
  logic [2:0] pointer_select_field;
  logic [32:0] diff;
  logic wr_en;

  assign new_op = decode_op(instr_i);
  assign accept = instr_valid_i && ready_reg;
  assign pointer_select_field = st0_reg[`ST0_ARP_LSB +: 3];
  // Borrow is the 33rd bit of an unsigned difference
  assign diff = {1'b0, acc_reg} - {1'b0, shadow_sum_register_reg} - {32'h0, ~st1_reg[`ST1_C]};
  assign wr_en = psel_i && penable_i && pready_reg && pwrite_i && !slverr_reg;

  // Repeat count forced to one for the pointer subtract
  always_comb begin
    reps = 8'h01;
    if (rpt_valid_i && (new_op != OP_POINTER_SUBTRACT_IMMEDIATE) && (rpt_n_i != 8'h00)) begin
      reps = rpt_n_i;
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  exec_sequencer u_seq (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .start_i(accept),
    .wait_p_i(ext_fetch_i ? wait_p_i : 4'h0),
    .reps_i(reps),
    .fire_o(fire),
    .last_o(last)
  );

  // Handshake, latched opcode and completion
  always_comb begin
    op_next = op_reg;
    instr_next = instr_reg;
    ready_next = ready_reg;
    done_next = fire && last;
    refused_next = accept && rpt_valid_i && (new_op == OP_POINTER_SUBTRACT_IMMEDIATE);
    if (accept) begin
      op_next = new_op;
      instr_next = instr_i;
      ready_next = 1'b0;
    end else if (fire && last) begin
      ready_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_reg <= OP_NONE;
      instr_reg <= 16'h0000;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      instr_reg <= instr_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
    end
  end

  // ****************************************
  // Datapath and software writes
  // ****************************************
  // Software writes other than to OFS_EXEC are refused while busy, so no clash with execution
  always_comb begin
    acc_next = acc_reg;
    shadow_sum_register_next = shadow_sum_register_reg;
    st0_next = st0_reg;
    st1_next = st1_reg;
    pc_next = pc_reg;
    ar_idx_next = ar_idx_reg;
    for (int i = 0; i < 8; i++) begin
      ar_next[i] = ar_reg[i];
    end
    if (wr_en) begin
      unique case (paddr_i)
        `OFS_ACC: acc_next = pwdata_i;
        `OFS_SHADOW_SUM_REGISTER: shadow_sum_register_next = pwdata_i;
        `OFS_ST0: st0_next = pwdata_i[15:0];
        `OFS_ST1: st1_next = pwdata_i[15:0];
        `OFS_AR_IDX: ar_idx_next = pwdata_i[2:0];
        `OFS_AR_DATA: ar_next[ar_idx_reg] = pwdata_i[15:0];
        default: ;
      endcase
    end
    if (fire) begin
      unique case (op_reg)
        OP_SUBTRACT_BUFFER_WITH_BORROW: begin
          acc_next = diff[31:0];
          st1_next[`ST1_C] = ~diff[32];
        end
        OP_POINTER_SUBTRACT_IMMEDIATE: begin
          // Pointer unit only; status words left alone
          ar_next[pointer_select_field] = ar_reg[pointer_select_field] - {8'h00, instr_reg[7:0]};
        end
        OP_SET_CONTROL_BIT_OP: begin
          unique case (instr_reg[3:0])
            `SET_CONTROL_BIT_OP_OVM: st0_next[`ST0_OVM] = 1'b1;
            `SET_CONTROL_BIT_OP_GLOBAL_IRQ_MASK_BIT: st0_next[`ST0_GLOBAL_IRQ_MASK_BIT] = 1'b1;
            `SET_CONTROL_BIT_OP_SXM: st1_next[`ST1_SXM] = 1'b1;
            `SET_CONTROL_BIT_OP_HM: st1_next[`ST1_HM] = 1'b1;
            `SET_CONTROL_BIT_OP_TC: st1_next[`ST1_TC] = 1'b1;
            `SET_CONTROL_BIT_OP_C: st1_next[`ST1_C] = 1'b1;
            `SET_CONTROL_BIT_OP_XF: st1_next[`ST1_XF] = 1'b1;
            `SET_CONTROL_BIT_OP_CNF: st1_next[`ST1_CNF] = 1'b1;
            default: ;
          endcase
        end
        default: ;
      endcase
      if (last) begin
        pc_next = pc_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_reg <= 32'h00000000;
      shadow_sum_register_reg <= 32'h00000000;
      st0_reg <= `ST0_RST;
      st1_reg <= `ST1_RST;
      pc_reg <= `PC_RST;
      ar_idx_reg <= 3'h0;
      for (int i = 0; i < 8; i++) begin
        ar_reg[i] <= 16'h0000;
      end
    end else begin
      acc_reg <= acc_next;
      shadow_sum_register_reg <= shadow_sum_register_next;
      st0_reg <= st0_next;
      st1_reg <= st1_next;
      pc_reg <= pc_next;
      ar_idx_reg <= ar_idx_next;
      for (int i = 0; i < 8; i++) begin
        ar_reg[i] <= ar_next[i];
      end
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Answer prepared in setup, so access takes exactly one cycle
  always_comb begin
    pready_next = psel_i && !penable_i;
    slverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel_i && !penable_i) begin
      prdata_next = 32'h00000000;
      // Busy flag as it will stand during the access phase
      slverr_next = !is_mapped(paddr_i) ||
                    (pwrite_i && !ready_next && (paddr_i != `OFS_EXEC));
      if (!pwrite_i) begin
        unique case (paddr_i)
          `OFS_ACC: prdata_next = acc_reg;
          `OFS_SHADOW_SUM_REGISTER: prdata_next = shadow_sum_register_reg;
          `OFS_ST0: prdata_next = {16'h0000, st0_reg};
          `OFS_ST1: prdata_next = {16'h0000, st1_reg};
          `OFS_AR_IDX: prdata_next = {29'h0, ar_idx_reg};
          `OFS_AR_DATA: prdata_next = {16'h0000, ar_reg[ar_idx_reg]};
          `OFS_EXEC: prdata_next = {pc_reg, 15'h0000, ~ready_reg};
          default: prdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      slverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      slverr_reg <= slverr_next;
    end
  end

  // Outputs straight from flops
  assign instr_ready_o = ready_reg;
  assign done_o = done_reg;
  assign rpt_refused_o = refused_reg;
  assign pc_o = pc_reg;
  assign xf_o = st1_reg[`ST1_XF];
  assign global_irq_mask_bit_o = st0_reg[`ST0_GLOBAL_IRQ_MASK_BIT];
  assign hm_o = st1_reg[`ST1_HM];
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = slverr_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // Busy cycle counter and expected length
  logic [8:0] cyc_reg;
  logic [8:0] exp_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_reg <= 9'h000;
      exp_reg <= 9'h000;
    end else if (accept) begin
      cyc_reg <= 9'h000;
      exp_reg <= {1'b0, reps} + (ext_fetch_i ? {5'h00, wait_p_i} : 9'h000);
    end else if (!ready_reg) begin
      cyc_reg <= cyc_reg + 9'h001;
    end
  end

  property p_subtract_buffer_with_borrow_result;
    fire && op_reg == OP_SUBTRACT_BUFFER_WITH_BORROW |=> acc_reg == $past(acc_reg) - $past(shadow_sum_register_reg)
      - {31'h0, ~$past(st1_reg[`ST1_C])} && $stable(shadow_sum_register_reg);
  endproperty
  a_subtract_buffer_with_borrow_result: assert property (p_subtract_buffer_with_borrow_result) else $error("borrow subtract wrong");

  property p_subtract_buffer_with_borrow_carry;
    fire && op_reg == OP_SUBTRACT_BUFFER_WITH_BORROW |=> st1_reg[`ST1_C] ==
      ({1'b0, $past(acc_reg)} >= {1'b0, $past(shadow_sum_register_reg)} + {32'h0, ~$past(st1_reg[`ST1_C])});
  endproperty
  a_subtract_buffer_with_borrow_carry: assert property (p_subtract_buffer_with_borrow_carry) else $error("carry after borrow wrong");

  property p_cycles;
    done_reg |-> cyc_reg == exp_reg;
  endproperty
  a_cycles: assert property (p_cycles) else $error("cycle count wrong");

  property p_single_onchip;
    accept && !ext_fetch_i && !rpt_valid_i |-> ##1 fire ##1 done_reg && ready_reg;
  endproperty
  a_single_onchip: assert property (p_single_onchip) else $error("not one cycle");

  property p_pointer_subtract_immediate_result;
    fire && op_reg == OP_POINTER_SUBTRACT_IMMEDIATE |=> ar_reg[$past(pointer_select_field)] ==
      $past(ar_reg[pointer_select_field]) - {8'h00, $past(instr_reg[7:0])};
  endproperty
  a_pointer_subtract_immediate_result: assert property (p_pointer_subtract_immediate_result) else $error("pointer subtract wrong");

  property p_pc_step;
    fire && last |=> pc_reg == $past(pc_reg) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not advanced");

  property p_pointer_subtract_immediate_status;
    fire && op_reg == OP_POINTER_SUBTRACT_IMMEDIATE |=> $stable(st0_reg) && $stable(st1_reg) && $stable(acc_reg);
  endproperty
  a_pointer_subtract_immediate_status: assert property (p_pointer_subtract_immediate_status) else $error("status touched");

  property p_pointer_subtract_immediate_norpt;
    accept && new_op == OP_POINTER_SUBTRACT_IMMEDIATE && rpt_valid_i && !ext_fetch_i |=>
      rpt_refused_o && fire && last;
  endproperty
  a_pointer_subtract_immediate_norpt: assert property (p_pointer_subtract_immediate_norpt) else $error("pointer op repeated");

  property p_set_control_bit_op_tc;
    fire && op_reg == OP_SET_CONTROL_BIT_OP && instr_reg[3:0] == `SET_CONTROL_BIT_OP_TC |=>
      st1_reg == ($past(st1_reg) | 16'h0800) && $stable(st0_reg);
  endproperty
  a_set_control_bit_op_tc: assert property (p_set_control_bit_op_tc) else $error("test flag set wrong");

  property p_set_control_bit_op_global_irq_mask_bit;
    fire && op_reg == OP_SET_CONTROL_BIT_OP && instr_reg[3:0] == `SET_CONTROL_BIT_OP_GLOBAL_IRQ_MASK_BIT |=> ##1 global_irq_mask_bit_o;
  endproperty
  a_set_control_bit_op_global_irq_mask_bit: assert property (p_set_control_bit_op_global_irq_mask_bit) else $error("mask not set");

  c_subtract_buffer_with_borrow: cover property (done_reg && op_reg == OP_SUBTRACT_BUFFER_WITH_BORROW);
  c_pointer_subtract_immediate_ext: cover property (accept && new_op == OP_POINTER_SUBTRACT_IMMEDIATE && ext_fetch_i && wait_p_i != 4'h0);
  c_rpt: cover property (accept && rpt_valid_i && rpt_n_i > 8'h02);
  c_apb_err: cover property (pready_o && pslverr_o);
endmodule : borrow_exec

// ==== borrow_exec_bench.sv ====
`timescale 1ns/1ns
`include "borrow_exec_cfg.svh"
module borrow_exec_bench;
  import borrow_exec_pkg::*;
  typedef struct {dword_t a; dword_t b; logic c; dword_t r; logic co;} row_s;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic instr_valid = 1'h0;
  logic ext_fetch = 1'h0;
  logic rpt_valid = 1'h0;
  word_t instr = 16'h0000;
  logic [3:0] wait_p = 4'h0;
  logic [7:0] rpt_n = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  dword_t pwdata = 32'h0000_0000;
  dword_t prdata;
  logic instr_ready, done, rpt_refused, xf, global_irq_mask_bit, hm, pready, pslverr, er;
  word_t pc;
  word_t pc_exp = 16'h0000;
  dword_t rd;
  int n_fail = 0;
  int checks = 0;
  // Borrow subtract cases: minuend, subtrahend, carry in, result, carry out
  row_s rows[5] = '{'{32'h2000_0000, 32'h1000_0000, 1'h1, 32'h1000_0000, 1'h1},
    '{32'h0009_8012, 32'h0009_8010, 1'h0, 32'h0000_0001, 1'h1},
    '{32'h0000_0000, 32'h0000_0001, 1'h1, 32'hFFFF_FFFF, 1'h0},
    '{32'h0000_0005, 32'h0000_0005, 1'h0, 32'hFFFF_FFFF, 1'h0},
    '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'h1, 32'h0000_0000, 1'h1}};
  // Control bit codes and the status words they should leave
  logic [3:0] nib[8] = '{4'h3, 4'h7, 4'h9, 4'hB, 4'hF, 4'hD, 4'h5, 4'h1};
  dword_t s0[8] = '{32'h800, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h200};
  dword_t s1[8] = '{32'h0, 32'h400, 32'h40, 32'h800, 32'h200, 32'h10, 32'h1000, 32'h0};

  // Clock, 100 ns period
  always #50 clk_sys = ~clk_sys;

  borrow_exec u_borrow_exec (
    .clk_sys_i(clk_sys), .arst_n_i(arst_n),
    .instr_valid_i(instr_valid), .instr_i(instr), .ext_fetch_i(ext_fetch),
    .wait_p_i(wait_p), .rpt_valid_i(rpt_valid), .rpt_n_i(rpt_n),
    .instr_ready_o(instr_ready), .done_o(done), .rpt_refused_o(rpt_refused),
    .pc_o(pc), .xf_o(xf), .global_irq_mask_bit_o(global_irq_mask_bit), .hm_o(hm),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Hung handshake ends the run at once
  task hang(input string what);
    n_fail++;
    $display("wrong value at %0t: no answer on %s", $time, what);
    summarize();
  endtask : hang

  // ****************************************
  // Bus and instruction drivers
  // ****************************************
  // One APB transfer; request held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] a, input dword_t d);
    int k;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) hang("apb");
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input dword_t d, input logic e);
    apb(1'h1, a, d);
    chk(er, e, "write error flag");
  endtask : wr

  task rdc(input logic [7:0] a, input dword_t exp, input logic e);
    apb(1'h0, a, 32'h0);
    chk(rd, exp, "read data");
    chk(er, e, "read error flag");
  endtask : rdc

  // Offer one instruction, then time its completion from the taking edge
  task issue(input word_t op, input logic ext, input logic [3:0] p, input logic rv,
             input logic [7:0] n, input int lat, input logic refused);
    int k;
    logic rf;
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    instr <= op;
    ext_fetch <= ext;
    wait_p <= p;
    rpt_valid <= rv;
    rpt_n <= n;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (instr_ready !== 1'h1 && k < 20);
    if (instr_ready !== 1'h1) hang("instruction ready");
    instr_valid <= 1'h0;
    rpt_valid <= 1'h0;
    k = 0;
    rf = 1'h0;
    do begin
      @(posedge clk_sys);
      k++;
      if (k == 1) rf = rpt_refused;
    end while (done !== 1'h1 && k < 40);
    if (done !== 1'h1) hang("instruction done");
    chk(k, lat, "cycles to done");
    chk(rf, refused, "repeat refused pulse");
    pc_exp++;
    chk(pc, pc_exp, "program counter");
  endtask : issue

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    chk(pc, 32'h0, "pc after reset");
    chk(global_irq_mask_bit, 1'h1, "mask after reset");
    chk(xf | hm, 1'h0, "flags after reset");
    rdc(`OFS_ST0, 32'h0200, 1'h0);
    rdc(`OFS_ST1, 32'h0, 1'h0);
    rdc(8'h40, 32'h0, 1'h1);
    // Borrow subtract table, one-cycle timing each
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_ACC, rows[i].a, 1'h0);
      wr(`OFS_SHADOW_SUM_REGISTER, rows[i].b, 1'h0);
      wr(`OFS_ST1, 32'(rows[i].c) << 9, 1'h0);
      issue(`OPC_SUBTRACT_BUFFER_WITH_BORROW, 1'h0, 4'h0, 1'h0, 8'h00, 2, 1'h0);
      rdc(`OFS_ACC, rows[i].r, 1'h0);
      rdc(`OFS_SHADOW_SUM_REGISTER, rows[i].b, 1'h0);
      rdc(`OFS_ST1, 32'(rows[i].co) << 9, 1'h0);
    end
    // Repeated three times from external memory with two wait cycles
    wr(`OFS_ACC, 32'hA, 1'h0);
    wr(`OFS_SHADOW_SUM_REGISTER, 32'h1, 1'h0);
    wr(`OFS_ST1, 32'h200, 1'h0);
    issue(`OPC_SUBTRACT_BUFFER_WITH_BORROW, 1'h1, 4'h2, 1'h1, 8'h03, 6, 1'h0);
    rdc(`OFS_ACC, 32'h7, 1'h0);
    // Pointer subtract on pointer 7, once under a refused repeat and once from external memory with three wait cycles
    wr(`OFS_ST0, 32'hE000, 1'h0);
    wr(`OFS_AR_IDX, 32'h7, 1'h0);
    wr(`OFS_AR_DATA, 32'h0, 1'h0);
    wr(`OFS_ST1, 32'h0A10, 1'h0);
    issue({`OPC_POINTER_SUBTRACT_IMMEDIATE_HI, 8'hFF}, 1'h0, 4'h0, 1'h1, 8'h05, 2, 1'h1);
    rdc(`OFS_AR_DATA, 32'hFF01, 1'h0);
    issue({`OPC_POINTER_SUBTRACT_IMMEDIATE_HI, 8'h01}, 1'h1, 4'h3, 1'h0, 8'h00, 5, 1'h0);
    rdc(`OFS_AR_DATA, 32'hFF00, 1'h0);
    rdc(`OFS_ST0, 32'hE000, 1'h0);
    rdc(`OFS_ST1, 32'h0A10, 1'h0);
    rdc(`OFS_ACC, 32'h7, 1'h0);
    // Every control bit code from cleared status words
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_ST0, 32'h0, 1'h0);
      wr(`OFS_ST1, 32'h0, 1'h0);
      issue({`OPC_SET_CONTROL_BIT_OP_HI, nib[i]}, 1'h0, 4'h0, 1'h0, 8'h00, 2, 1'h0);
      rdc(`OFS_ST0, s0[i], 1'h0);
      rdc(`OFS_ST1, s1[i], 1'h0);
      chk(xf, s1[i][4], "external flag pin");
      chk(hm, s1[i][6], "hold output");
      chk(global_irq_mask_bit, s0[i][9], "mask output");
    end
    // Register write while an instruction is busy must be dropped
    wr(`OFS_ACC, 32'h5, 1'h0);
    fork
      issue(`OPC_SUBTRACT_BUFFER_WITH_BORROW, 1'h1, 4'h4, 1'h0, 8'h00, 6, 1'h0);
      begin
        repeat (3) @(posedge clk_sys);
        wr(`OFS_ACC, 32'h1234, 1'h1);
      end
    join
    // Carry left clear by the last control bit case, so 5 - 1 - 1
    rdc(`OFS_ACC, 32'h3, 1'h0);
    rdc(`OFS_ST1, 32'h200, 1'h0);
    // Unknown opcode is taken, changes nothing but the program counter
    issue(16'h0000, 1'h0, 4'h0, 1'h0, 8'h00, 2, 1'h0);
    rdc(`OFS_ACC, 32'h3, 1'h0);
    rdc(`OFS_EXEC, {pc_exp, 16'h0000}, 1'h0);
    // Second reset in mid-run
    @(posedge clk_sys);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'h1;
    pc_exp = 16'h0000;
    @(posedge clk_sys);
    chk(pc, 32'h0, "pc after second reset");
    chk(global_irq_mask_bit, 1'h1, "mask after second reset");
    rdc(`OFS_ACC, 32'h0, 1'h0);
    issue(`OPC_SUBTRACT_BUFFER_WITH_BORROW, 1'h0, 4'h0, 1'h0, 8'h00, 2, 1'h0);
    summarize();
  end
endmodule : borrow_exec_bench

// ==== borrow_exec_cfg.svh ====
`ifndef BORROW_EXEC_CFG_SVH
`define BORROW_EXEC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_ACC 8'h00
`define OFS_SHADOW_SUM_REGISTER 8'h04
`define OFS_ST0 8'h08
`define OFS_ST1 8'h0C
`define OFS_AR_IDX 8'h10
`define OFS_AR_DATA 8'h14
`define OFS_EXEC 8'h18

// ****************************************
// Status word bit positions
// ****************************************
`define ST0_ARP_LSB 13
`define ST0_OVM 11
`define ST0_GLOBAL_IRQ_MASK_BIT 9
`define ST1_CNF 12
`define ST1_TC 11
`define ST1_SXM 10
`define ST1_C 9
`define ST1_HM 6
`define ST1_XF 4

// ****************************************
// Reset values
// ****************************************
`define ST0_RST 16'h0200
`define ST1_RST 16'h0000
`define PC_RST 16'h0000

// ****************************************
// Opcodes
// ****************************************
`define OPC_SUBTRACT_BUFFER_WITH_BORROW 16'hBE19
`define OPC_POINTER_SUBTRACT_IMMEDIATE_HI 8'h7C
`define OPC_SET_CONTROL_BIT_OP_HI 12'hBE4
`define SET_CONTROL_BIT_OP_OVM 4'h3
`define SET_CONTROL_BIT_OP_SXM 4'h7
`define SET_CONTROL_BIT_OP_HM 4'h9
`define SET_CONTROL_BIT_OP_TC 4'hB
`define SET_CONTROL_BIT_OP_C 4'hF
`define SET_CONTROL_BIT_OP_XF 4'hD
`define SET_CONTROL_BIT_OP_CNF 4'h5
`define SET_CONTROL_BIT_OP_GLOBAL_IRQ_MASK_BIT 4'h1

`endif

// ==== borrow_exec_pkg.sv ====
package borrow_exec_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_SUBTRACT_BUFFER_WITH_BORROW, OP_POINTER_SUBTRACT_IMMEDIATE, OP_SET_CONTROL_BIT_OP} op_e;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_EXEC} seq_state_e;
  typedef logic [15:0] word_t;
  typedef logic [31:0] dword_t;
endpackage : borrow_exec_pkg

// ==== exec_sequencer.sv ====
`timescale 1ns/1ns
module exec_sequencer (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Request
  input wire logic start_i,
  input wire logic [3:0] wait_p_i,
  input wire logic [7:0] reps_i,
  // Progress
  output logic fire_o,
  output logic last_o
);
  import borrow_exec_pkg::*;

  seq_state_e state_reg;
  seq_state_e state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] reps_reg;
  logic [7:0] reps_next;

  // Wait states first, then one execution per cycle
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    reps_next = reps_reg;
    unique case (state_reg)
      SEQ_IDLE: begin
        if (start_i) begin
          reps_next = reps_i;
          if (wait_p_i != 4'h0) begin
            state_next = SEQ_WAIT;
            cnt_next = {4'h0, wait_p_i};
          end else begin
            state_next = SEQ_EXEC;
            cnt_next = reps_i;
          end
        end
      end
      SEQ_WAIT: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          state_next = SEQ_EXEC;
          cnt_next = reps_reg;
        end
      end
      SEQ_EXEC: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          state_next = SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= SEQ_IDLE;
      cnt_reg <= 8'h00;
      reps_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      reps_reg <= reps_next;
    end
  end

  // One operation applied per exec cycle
  assign fire_o = (state_reg == SEQ_EXEC);
  assign last_o = fire_o && (cnt_reg == 8'h01);
endmodule : exec_sequencer
